// ### shared/lanra_pkg.sv
// package of constants and types for the link auto-negotiation receive block
//----------------------------------------------------------------------------
// Overview of operation
// RQ1 - partner is negotiation-able after 6 to 17 evenly spaced pulses
// RQ2 - data from an incomplete first identifying burst is thrown away
// RQ3 - the first pulse of each burst is taken as a clock pulse
// RQ4 - every clock pulse restarts both data detect timers
// RQ5 - a pulse inside the data window decodes as a one bit
// RQ6 - no pulse in the window is a zero; late pulse is next clock
// RQ7 - after completion only the chosen technology PMA sees the medium
// RQ8 - while negotiating, medium feeds pulse receivers and TX and T4 checks
// RQ9 - receive side builds ability, acknowledge and consistency matches
// RQ10 - before pulse bursts, medium reaches only NLP, TX and T4 checks
// RQ11 - wait timer expiry with one ready PMA enables that PMA
// RQ12 - parallel detection disables all other PMAs and flags completion
// RQ13 - parallel detection sets its technology bit in partner ability
// RQ14 - renegotiation disables link tests and halts transmit until break
// RQ15 - after break timer, bursts resume with a valid base page
// RQ16 - priority resolution enables the best commonly advertised PMA
// RQ17 - reserved partner ability bits are ignored in resolution
// RQ18 - a parallel detected technology is the highest common one
// RQ19 - no common technology gives NULL and a failed link status
// RQ20 - timer durations are design parameters in clock cycles
//----------------------------------------------------------------------------
package lanra_pkg;

   // clock rate, used to turn microseconds into cycles
   localparam int CLK_MHZ = 100;

   // timer durations in microseconds (plain defaults)
   localparam int FLP_TEST_MIN_US = 5;
   localparam int FLP_TEST_MAX_US = 185;
   localparam int DATA_DETECT_MIN_US = 15;
   localparam int DATA_DETECT_MAX_US = 78;
   localparam int AUTONEG_WAIT_US = 500000;
   localparam int BREAK_LINK_US = 1200000;

   // derived cycle counts
   localparam int FLP_TEST_MIN_CYC = FLP_TEST_MIN_US * CLK_MHZ;
   localparam int FLP_TEST_MAX_CYC = FLP_TEST_MAX_US * CLK_MHZ;
   localparam int DATA_DETECT_MIN_CYC = DATA_DETECT_MIN_US * CLK_MHZ;
   localparam int DATA_DETECT_MAX_CYC = DATA_DETECT_MAX_US * CLK_MHZ;
   localparam int AUTONEG_WAIT_CYC = AUTONEG_WAIT_US * CLK_MHZ;
   localparam int BREAK_LINK_CYC = BREAK_LINK_US * CLK_MHZ;

   // pulse run bounds for partner identification, code word length and match count
   localparam logic [4:0] RUN_MIN = 5'h06;
   localparam logic [4:0] RUN_MAX = 5'h11;
   localparam logic [4:0] CODEWORD_BITS = 5'h10;
   localparam logic [1:0] MATCH_NEED = 2'h3;

   // register offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_LOCAL_ABILITY = 4'h4;
   localparam logic [3:0] REG_PARTNER_ABILITY = 4'h5;
   localparam logic [3:0] REG_HCD = 4'h6;

   // field positions
   localparam int CTRL_RESTART = 0;
   localparam int AB_10T = 5;
   localparam int AB_10FD = 6;
   localparam int AB_TX = 7;
   localparam int AB_TXFD = 8;
   localparam int AB_T4 = 9;
   localparam int AB_ACK = 14;
   localparam logic [15:0] AB_TECH_MASK = 16'h03E0;
   localparam logic [15:0] LOCAL_ABILITY_RST = 16'h03E1;

   // pma indices
   localparam int PMA_10T = 0;
   localparam int PMA_TX = 1;
   localparam int PMA_T4 = 2;

   typedef enum logic [2:0] {
      HCD_NULL, HCD_10T, HCD_10FD, HCD_TX, HCD_TXFD, HCD_T4
   } lanra_hcd_e;

   typedef enum logic [2:0] {
      ARB_BREAK, ARB_ABILITY, ARB_LSC, ARB_ACK, ARB_GOOD_CHECK, ARB_GOOD
   } lanra_arb_e;

   // receive switch routing of the medium
   typedef struct packed {
      logic to_flp;
      logic to_nlp;
      logic to_tx_chk;
      logic to_t4_chk;
      logic [2:0] to_pma;
   } lanra_route_s;

   // match indications from the receive side
   typedef struct packed {
      logic ability;
      logic acknowledge;
      logic consistency;
   } lanra_match_s;

   // highest common technology of two ability words, best first
   function automatic lanra_hcd_e lanra_resolve(input logic [15:0] loc,
                                                input logic [15:0] prt);
      logic [15:0] com;
      com = loc & prt & AB_TECH_MASK; // RQ17
      if (com[AB_TXFD]) lanra_resolve = HCD_TXFD; // RQ16
      else if (com[AB_T4]) lanra_resolve = HCD_T4;
      else if (com[AB_TX]) lanra_resolve = HCD_TX;
      else if (com[AB_10FD]) lanra_resolve = HCD_10FD;
      else if (com[AB_10T]) lanra_resolve = HCD_10T;
      else lanra_resolve = HCD_NULL; // RQ19
   endfunction : lanra_resolve

   // pma one-hot that carries a technology
   function automatic logic [2:0] lanra_pma_of(input lanra_hcd_e h);
      unique case (h)
         HCD_10T, HCD_10FD: lanra_pma_of = 3'h1;
         HCD_TX, HCD_TXFD: lanra_pma_of = 3'h2;
         HCD_T4: lanra_pma_of = 3'h4;
         default: lanra_pma_of = 3'h0;
      endcase
   endfunction : lanra_pma_of

endpackage : lanra_pkg

// ### rtl/lanra_top.sv
// receive decoding and arbitration of the link auto-negotiation unit
//
// Design decisions made here: the plain strobed port and the placing of the registers.
module lanra_top #(
   parameter int FLP_MAX_CYC = lanra_pkg::FLP_TEST_MAX_CYC, // RQ20
   parameter int DD_MAX_CYC = lanra_pkg::DATA_DETECT_MAX_CYC,
   parameter int WAIT_CYC = lanra_pkg::AUTONEG_WAIT_CYC,
   parameter int BREAK_CYC = lanra_pkg::BREAK_LINK_CYC
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic mdi_pulse,
   input wire logic [2:0] pma_ready,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output lanra_pkg::lanra_route_s rx_route,
   output logic [2:0] link_control,
   output logic link_tests_off,
   output logic tx_halt,
   output logic tx_flp_en,
   output logic [15:0] tx_code_word,
   output logic an_complete,
   output logic hcd_fail,
   output lanra_pkg::lanra_match_s rx_match
);

   //-------------------------------------------------------------------------
   // state
   //-------------------------------------------------------------------------
   typedef struct packed {
      logic s1_pulse;
      logic s2_pulse;
      logic s3_pulse;
      logic [2:0] s1_rdy;
      logic [2:0] s2_rdy;
      logic [15:0] gap_cnt;
      logic [15:0] clk_cnt;
      logic in_burst;
      logic data_seen;
      logic bad;
      logic [4:0] bit_cnt;
      logic [4:0] run_cnt;
      logic [15:0] shreg;
      logic an_able;
      logic [15:0] last_word;
      logic [15:0] ab_word;
      logic [1:0] match_cnt;
      logic [1:0] ack_cnt;
      lanra_pkg::lanra_match_s match;
      lanra_pkg::lanra_arb_e arb;
      logic [27:0] tmr;
      logic pd_sel;
      lanra_pkg::lanra_route_s route;
      logic [2:0] link_ctl;
      logic tests_off;
      logic halt;
      logic flp_en;
      logic tx_ack;
      logic complete;
      lanra_pkg::lanra_hcd_e hcd;
      logic fail;
      logic [15:0] local_ab;
      logic [15:0] partner_ab;
      logic [15:0] rd_data;
   } lanra_state_s;

   lanra_state_s st;
   lanra_state_s next_st;

   // wide constants sized once for the counters
   localparam logic [15:0] FLP_MIN = 16'(lanra_pkg::FLP_TEST_MIN_CYC);
   localparam logic [15:0] FLP_MAX = 16'(FLP_MAX_CYC);
   localparam logic [15:0] DD_MIN = 16'(lanra_pkg::DATA_DETECT_MIN_CYC);
   localparam logic [15:0] DD_MAX = 16'(DD_MAX_CYC);
   localparam logic [27:0] WAIT_T = 28'(WAIT_CYC);
   localparam logic [27:0] BREAK_T = 28'(BREAK_CYC);

   logic pulse_edge;
   logic rdy_onehot;
   logic word_valid;
   logic [15:0] new_word;

   assign pulse_edge = st.s2_pulse & ~st.s3_pulse;
   assign rdy_onehot = (st.s2_rdy != 3'h0)
                       && ((st.s2_rdy & (st.s2_rdy - 3'h1)) == 3'h0);
   // a burst ends once the medium is quiet longer than pulse spacing
   assign word_valid = st.in_burst && (st.gap_cnt >= FLP_MAX)
                       && !st.bad
                       && (st.bit_cnt == lanra_pkg::CODEWORD_BITS); // RQ2
   assign new_word = st.shreg;

   //-------------------------------------------------------------------------
   // next state
   //-------------------------------------------------------------------------
   always_comb begin
      logic [15:0] masked;
      logic restart;
      lanra_pkg::lanra_hcd_e res;
      masked = 16'h0000;
      restart = 1'b0;
      res = lanra_pkg::HCD_NULL;
      next_st = st;

      // two flip-flop synchronisers, third stage only for edge finding
      next_st.s1_pulse = mdi_pulse;
      next_st.s2_pulse = st.s1_pulse;
      next_st.s3_pulse = st.s2_pulse;
      next_st.s1_rdy = pma_ready;
      next_st.s2_rdy = st.s1_rdy;

      // saturating interval counters
      if (st.gap_cnt != 16'hFFFF) next_st.gap_cnt = st.gap_cnt + 16'h0001;
      if (st.clk_cnt != 16'hFFFF) next_st.clk_cnt = st.clk_cnt + 16'h0001;

      // pulse decoding within a burst
      if (pulse_edge) begin
         next_st.gap_cnt = 16'h0000;
         if (!st.in_burst) begin
            next_st.in_burst = 1'b1; // RQ3
            next_st.clk_cnt = 16'h0000; // RQ4
            next_st.data_seen = 1'b0;
            next_st.bad = 1'b0;
            next_st.bit_cnt = 5'h00;
            next_st.run_cnt = 5'h01;
         end else begin
            // spacing check of consecutive pulses
            if (st.gap_cnt >= FLP_MIN && st.gap_cnt < FLP_MAX) begin // RQ1
               if (st.run_cnt != 5'h1F) next_st.run_cnt = st.run_cnt + 5'h01;
            end else begin
               next_st.run_cnt = 5'h01;
            end
            if (st.clk_cnt > DD_MIN && st.clk_cnt < DD_MAX) begin
               // two data pulses in one window spoil the word
               if (st.data_seen) next_st.bad = 1'b1;
               next_st.data_seen = 1'b1; // RQ5
            end else if (st.clk_cnt >= DD_MAX) begin
               next_st.shreg = {st.data_seen, st.shreg[15:1]}; // RQ6
               next_st.clk_cnt = 16'h0000; // RQ4
               next_st.data_seen = 1'b0;
               if (st.bit_cnt == lanra_pkg::CODEWORD_BITS) next_st.bad = 1'b1;
               else next_st.bit_cnt = st.bit_cnt + 5'h01;
            end else begin
               next_st.bad = 1'b1;
            end
         end
      end

      // identification after a run of well spaced pulses
      if (next_st.run_cnt == lanra_pkg::RUN_MIN
          && st.run_cnt < lanra_pkg::RUN_MIN
          && next_st.run_cnt <= lanra_pkg::RUN_MAX) begin
         next_st.an_able = 1'b1; // RQ1
      end

      // end of burst; an incomplete one leaves no word behind
      if (st.in_burst && st.gap_cnt >= FLP_MAX) begin
         next_st.in_burst = 1'b0; // RQ2
      end

      // match indications
      masked = new_word & ~(16'h0001 << lanra_pkg::AB_ACK);
      next_st.match = '0;
      if (word_valid) begin
         next_st.last_word = masked;
         if (masked == st.last_word) begin
            if (st.match_cnt != lanra_pkg::MATCH_NEED)
               next_st.match_cnt = st.match_cnt + 2'h1;
         end else begin
            next_st.match_cnt = 2'h1;
         end
         if (new_word[lanra_pkg::AB_ACK]) begin
            if (st.ack_cnt != lanra_pkg::MATCH_NEED)
               next_st.ack_cnt = st.ack_cnt + 2'h1;
         end else begin
            next_st.ack_cnt = 2'h0;
         end
         if (next_st.match_cnt == lanra_pkg::MATCH_NEED) begin
            next_st.match.ability = 1'b1; // RQ9
            if (!st.tx_ack) next_st.ab_word = masked;
         end
         if (next_st.ack_cnt == lanra_pkg::MATCH_NEED
             && next_st.match_cnt == lanra_pkg::MATCH_NEED) begin
            next_st.match.acknowledge = 1'b1; // RQ9
            // compare with the word latched at the last ability match before the ack bit went out
            next_st.match.consistency = (masked == next_st.ab_word); // RQ9
         end
      end

      // register writes
      if (reg_wr) begin
         unique case (reg_addr)
            lanra_pkg::REG_CTRL: restart = reg_wdata[lanra_pkg::CTRL_RESTART];
            lanra_pkg::REG_LOCAL_ABILITY: next_st.local_ab = reg_wdata;
            default: ;
         endcase
      end

      // arbitration
      if (st.tmr != 28'hFFFFFFF) next_st.tmr = st.tmr + 28'h0000001;
      unique case (st.arb)
         lanra_pkg::ARB_BREAK: begin
            if (st.tmr >= BREAK_T) begin
               next_st.arb = lanra_pkg::ARB_ABILITY;
               next_st.halt = 1'b0; // RQ15
               next_st.tests_off = 1'b0;
               next_st.flp_en = 1'b1; // RQ15
               next_st.route = '{to_nlp: 1'b1, to_tx_chk: 1'b1,
                                 to_t4_chk: 1'b1, default: '0};
               next_st.an_able = 1'b0;
            end
         end
         lanra_pkg::ARB_ABILITY: begin
            if (st.an_able) begin
               next_st.arb = lanra_pkg::ARB_ACK;
               next_st.route = '{to_flp: 1'b1, to_nlp: 1'b1, to_tx_chk: 1'b1,
                                 to_t4_chk: 1'b1, default: '0}; // RQ8
            end else if (rdy_onehot) begin
               next_st.arb = lanra_pkg::ARB_LSC;
               next_st.tmr = 28'h0000000;
            end
         end
         lanra_pkg::ARB_LSC: begin
            if (st.an_able) begin
               next_st.arb = lanra_pkg::ARB_ACK;
               next_st.route = '{to_flp: 1'b1, to_nlp: 1'b1, to_tx_chk: 1'b1,
                                 to_t4_chk: 1'b1, default: '0}; // RQ8
            end else if (!rdy_onehot) begin
               next_st.arb = lanra_pkg::ARB_ABILITY;
            end else if (st.tmr >= WAIT_T) begin
               // parallel detection picks the single ready pma
               next_st.arb = lanra_pkg::ARB_GOOD_CHECK;
               next_st.tmr = 28'h0000000;
               next_st.pd_sel = 1'b1;
               next_st.link_ctl = st.s2_rdy; // RQ11 RQ12
               next_st.complete = 1'b1; // RQ12
               next_st.route = '{to_pma: st.s2_rdy, default: '0}; // RQ7
               next_st.fail = 1'b0;
               unique case (1'b1)
                  st.s2_rdy[lanra_pkg::PMA_TX]: begin
                     next_st.hcd = lanra_pkg::HCD_TX; // RQ18
                     next_st.partner_ab[lanra_pkg::AB_TX] = 1'b1; // RQ13
                  end
                  st.s2_rdy[lanra_pkg::PMA_T4]: begin
                     next_st.hcd = lanra_pkg::HCD_T4; // RQ18
                     next_st.partner_ab[lanra_pkg::AB_T4] = 1'b1; // RQ13
                  end
                  default: begin
                     next_st.hcd = lanra_pkg::HCD_10T; // RQ18
                     next_st.partner_ab[lanra_pkg::AB_10T] = 1'b1; // RQ13
                  end
               endcase
            end
         end
         lanra_pkg::ARB_ACK: begin
            if (st.match.ability) begin
               next_st.tx_ack = 1'b1;
               next_st.partner_ab = st.ab_word;
            end
            if (st.match.acknowledge) begin
               if (st.match.consistency) begin
                  res = lanra_pkg::lanra_resolve(st.local_ab,
                                                 st.ab_word); // RQ16
                  next_st.arb = lanra_pkg::ARB_GOOD_CHECK;
                  next_st.tmr = 28'h0000000;
                  next_st.pd_sel = 1'b0;
                  next_st.hcd = res;
                  next_st.fail = (res == lanra_pkg::HCD_NULL); // RQ19
                  next_st.link_ctl = lanra_pkg::lanra_pma_of(res); // RQ16
                  next_st.route = '{to_pma: lanra_pkg::lanra_pma_of(res),
                                    default: '0}; // RQ7
                  next_st.flp_en = 1'b0;
               end else begin
                  restart = 1'b1;
               end
            end
         end
         lanra_pkg::ARB_GOOD_CHECK: begin
            // selected pma must report ready before the wait runs out
            if (!st.fail && (st.s2_rdy & st.link_ctl) != 3'h0) begin
               next_st.arb = lanra_pkg::ARB_GOOD;
               next_st.complete = 1'b1;
               next_st.flp_en = 1'b0;
            end else if (st.tmr >= WAIT_T) begin
               restart = 1'b1;
            end
         end
         lanra_pkg::ARB_GOOD: begin
            if ((st.s2_rdy & st.link_ctl) == 3'h0) restart = 1'b1;
         end
      endcase

      // renegotiation wins over every state
      if (restart) begin
         next_st.arb = lanra_pkg::ARB_BREAK;
         next_st.tmr = 28'h0000000;
         next_st.tests_off = 1'b1; // RQ14
         next_st.halt = 1'b1; // RQ14
         next_st.flp_en = 1'b0;
         next_st.route = '0; // RQ14
         next_st.link_ctl = 3'h0;
         next_st.complete = 1'b0;
         next_st.tx_ack = 1'b0;
         next_st.an_able = 1'b0;
         next_st.pd_sel = 1'b0;
         next_st.hcd = lanra_pkg::HCD_NULL;
         next_st.fail = 1'b0;
         next_st.match_cnt = 2'h0;
         next_st.ack_cnt = 2'h0;
      end

      // read data stand one cycle after the read strobe
      next_st.rd_data = 16'h0000;
      if (reg_rd) begin
         unique case (reg_addr)
            lanra_pkg::REG_STATUS:
               next_st.rd_data = {8'h00, st.fail, st.pd_sel, st.an_able,
                                  st.complete, 1'b0, 3'(st.arb)};
            lanra_pkg::REG_LOCAL_ABILITY: next_st.rd_data = st.local_ab;
            lanra_pkg::REG_PARTNER_ABILITY: next_st.rd_data = st.partner_ab;
            lanra_pkg::REG_HCD: next_st.rd_data = {13'h0000, 3'(st.hcd)};
            default: next_st.rd_data = 16'h0000;
         endcase
      end
   end

   //-------------------------------------------------------------------------
   // registers
   //-------------------------------------------------------------------------
   // reset leaves the unit listening for pulses with normal checks routed
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
         st.arb <= lanra_pkg::ARB_ABILITY;
         st.flp_en <= 1'b1;
         st.route <= '{to_nlp: 1'b1, to_tx_chk: 1'b1,
                       to_t4_chk: 1'b1, default: '0}; // RQ10
         st.local_ab <= lanra_pkg::LOCAL_ABILITY_RST;
         st.hcd <= lanra_pkg::HCD_NULL;
      end else begin
         st <= next_st;
      end
   end

   //-------------------------------------------------------------------------
   // outputs, all taken from the state register
   //-------------------------------------------------------------------------
   assign reg_rdata = st.rd_data;
   assign rx_route = st.route;
   assign link_control = st.link_ctl;
   assign link_tests_off = st.tests_off;
   assign tx_halt = st.halt;
   assign tx_flp_en = st.flp_en;
   assign tx_code_word = {st.local_ab[15], st.tx_ack,
                          st.local_ab[13:0]}; // RQ15
   assign an_complete = st.complete;
   assign hcd_fail = st.fail;
   assign rx_match = st.match;

endmodule : lanra_top

// ### bench/lanra_chk_sva.sv
// assertion checker for the negotiation receive and arbitration block
module lanra_chk (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire lanra_pkg::lanra_route_s rx_route,
   input wire logic [2:0] link_control,
   input wire logic link_tests_off,
   input wire logic tx_halt,
   input wire logic tx_flp_en,
   input wire logic an_complete,
   input wire logic hcd_fail,
   input wire lanra_pkg::lanra_match_s rx_match
);
   timeunit 1ns;
   timeprecision 100ps;
   //------------------------------------------------------------
   // properties
   //------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   single_pma_a: assert property (
      an_complete && !hcd_fail |-> $onehot(link_control))
      else $error("completion without one enabled pma");
   route_one_a: assert property (
      an_complete && !hcd_fail |-> rx_route.to_pma == link_control)
      else $error("medium not routed to the enabled pma");
   route_neg_a: assert property (
      link_control == 3'h0 && !link_tests_off
      |-> rx_route.to_pma == 3'h0 && rx_route.to_nlp)
      else $error("medium reaches a pma while negotiating");
   break_quiet_a: assert property (
      link_tests_off |-> tx_halt && !tx_flp_en)
      else $error("transmit active during break");
   restart_go_a: assert property (
      reg_wr && reg_addr == lanra_pkg::REG_CTRL && reg_wdata[0]
      |-> ##[1:3] link_tests_off)
      else $error("restart request did not break the link");
   break_hold_a: assert property (
      $rose(tx_halt) |=> tx_halt [*8])
      else $error("break ended too early");
   resume_flp_a: assert property (
      $fell(tx_halt) |-> tx_flp_en)
      else $error("bursts not resumed after break");
   fail_null_a: assert property (
      hcd_fail |-> link_control == 3'h0)
      else $error("pma enabled without common technology");
   match_pulse_a: assert property (
      rx_match.ability |=> !rx_match.ability)
      else $error("ability match longer than one cycle");

   // main scenarios reached
   cover property ($rose(an_complete));
   cover property ($rose(link_tests_off));
   cover property (rx_match.ability);
endmodule : lanra_chk

// ### bench/lanra_partner.sv
// remote station model that sends pulse bursts onto the medium
module lanra_partner #(
   parameter int CLK_GAP = 2040,
   parameter int DATA_AT = 1530,
   parameter int WIDTH = 10
) (
   input wire logic ref_clk,
   output logic mdi_pulse
);
   timeunit 1ns;
   timeprecision 100ps;
   //------------------------------------------------------------
   // burst generation
   //------------------------------------------------------------
   // medium is quiet between bursts, so the line rests low
   initial mdi_pulse = 1'b0;

   // one pulse whose rise comes gap cycles after the previous rise
   task automatic pulse(input int gap);
      repeat (gap - WIDTH) @(posedge ref_clk);
      mdi_pulse <= 1'b1;
      repeat (WIDTH) @(posedge ref_clk);
      mdi_pulse <= 1'b0;
   endtask : pulse

   // clock pulse first, then bit 0 up to bit 15, each closed by a clock
   task automatic send_burst(input logic [15:0] word);
      pulse(WIDTH);
      for (int i = 0; i < 16; i++) begin
         if (word[i]) begin
            pulse(DATA_AT);
            pulse(CLK_GAP - DATA_AT);
         end else begin
            pulse(CLK_GAP); // no data pulse gives a zero
         end
      end
   endtask : send_burst
endmodule : lanra_partner

// ### bench/testbench.sv
// self-checking bench for the negotiation receive and arbitration block
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'b0;
   logic rstn, mdi_pulse, reg_wr, reg_rd, link_tests_off, tx_halt;
   logic tx_flp_en, an_complete, hcd_fail;
   logic seen_ab = 1'b0;
   logic seen_flp = 1'b0;
   logic seen_ok = 1'b0;
   logic [2:0] pma_ready, link_control;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, tx_code_word, d;
   lanra_pkg::lanra_route_s rx_route;
   lanra_pkg::lanra_match_s rx_match;
   int miscompares = 0;
   int total_checks = 0;
   int n;

   always #5 ref_clk = ~ref_clk;

   // latch indications that end before the checks so the sequence can look at them later
   always @(posedge ref_clk) begin
      if (rx_match.ability === 1'b1) seen_ab <= 1'b1;
      if (rx_route.to_flp === 1'b1) seen_flp <= 1'b1;
      if (rx_match.consistency === 1'b1) seen_ok <= 1'b1;
   end

   lanra_partner u_prt (.ref_clk(ref_clk), .mdi_pulse(mdi_pulse));

   // short timers keep three full bursts inside the run budget
   lanra_top #(.FLP_MAX_CYC(2100), .DD_MAX_CYC(1560), .WAIT_CYC(200),
      .BREAK_CYC(200)) u_dut (.ref_clk(ref_clk), .rstn(rstn),
      .mdi_pulse(mdi_pulse), .pma_ready(pma_ready), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rx_route(rx_route),
      .link_control(link_control), .link_tests_off(link_tests_off),
      .tx_halt(tx_halt), .tx_flp_en(tx_flp_en),
      .tx_code_word(tx_code_word), .an_complete(an_complete),
      .hcd_fail(hcd_fail), .rx_match(rx_match));

   //------------------------------------------------------------
   // access and comparison tasks
   //------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      v = reg_rdata;
   endtask : rd

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   //------------------------------------------------------------
   // main sequence
   //------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      pma_ready = 3'h0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      chk({9'h000, rx_route}, 16'h0038);
      rd(lanra_pkg::REG_LOCAL_ABILITY, d);
      chk(d, 16'h03E1);
      wr(lanra_pkg::REG_PARTNER_ABILITY, 16'hFFFF);
      rd(lanra_pkg::REG_PARTNER_ABILITY, d);
      chk(d, 16'h0000);
      rd(4'hA, d);
      chk(d, 16'h0000);
      // single ready pma found by parallel detection
      pma_ready <= 3'h2;
      n = 0;
      while (an_complete !== 1'b1 && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 400) begin
         miscompares++; // a hang counts as a mismatch
         end_sim();
      end
      chk({15'h0000, n >= 200 && n < 216}, 16'h0001);
      chk({13'h0000, link_control}, 16'h0002);
      chk({13'h0000, rx_route.to_pma}, 16'h0002);
      rd(lanra_pkg::REG_PARTNER_ABILITY, d);
      chk(d, 16'h0080);
      rd(lanra_pkg::REG_HCD, d);
      chk(d, {13'h0000, lanra_pkg::HCD_TX});
      // renegotiation: break, then bursts again
      wr(lanra_pkg::REG_CTRL, 16'h0001);
      pma_ready <= 3'h0;
      repeat (3) @(posedge ref_clk);
      chk({13'h0000, link_tests_off, tx_halt, tx_flp_en}, 16'h0006);
      n = 0;
      while (tx_halt !== 1'b0 && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 400) begin
         miscompares++; // a hang counts as a mismatch
         end_sim();
      end
      chk({15'h0000, n >= 190 && n < 205}, 16'h0001);
      repeat (2) @(posedge ref_clk);
      chk({15'h0000, tx_flp_en}, 16'h0001);
      chk(tx_code_word, 16'h03E1);
      // three equal bursts carrying a reserved bit and the ack bit
      // ready only once bursts are seen, so parallel detection stays out
      repeat (3) begin
         u_prt.send_burst(16'h4581);
         pma_ready <= 3'h2;
         repeat (2200) @(posedge ref_clk);
      end
      chk({15'h0000, seen_flp}, 16'h0001);
      chk({15'h0000, seen_ab}, 16'h0001);
      chk({15'h0000, seen_ok}, 16'h0001);
      chk({11'h000, an_complete, hcd_fail, link_control}, 16'h0012);
      chk(tx_code_word, 16'h43E1);
      rd(lanra_pkg::REG_STATUS, d);
      chk(d, 16'h0035);
      rd(lanra_pkg::REG_HCD, d);
      chk(d, {13'h0000, lanra_pkg::HCD_TXFD});
      rd(lanra_pkg::REG_PARTNER_ABILITY, d);
      chk(d, 16'h0581);
      end_sim();
   end
endmodule : testbench

bind lanra_top lanra_chk u_chk (.ref_clk(ref_clk), .rstn(rstn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .rx_route(rx_route), .link_control(link_control),
   .link_tests_off(link_tests_off), .tx_halt(tx_halt),
   .tx_flp_en(tx_flp_en), .an_complete(an_complete),
   .hcd_fail(hcd_fail), .rx_match(rx_match));
